// [pgt_pkg.sv]
// Package for the pulse generator timer and trip control block
// Assumes an AXI4-Lite slave with 32-bit data and word-aligned registers
package pgt_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_OUT_CTRL_UPPER = 8'h00;
  localparam logic [7:0] OFS_TIMER_CTRL     = 8'h04;
  localparam logic [7:0] OFS_COMPARE_CLEAR  = 8'h08;
  localparam logic [7:0] OFS_TIMER_BUFFER   = 8'h0C;
  localparam logic [7:0] OFS_COUNTER        = 8'h10;
  localparam logic [7:0] OFS_NOISE_CTRL     = 8'h14;
  localparam logic [7:0] OFS_PORT_LATCH     = 8'h18;
  localparam logic [7:0] OFS_EVENT_STATUS   = 8'h1C;

  // Address field used for decode
  localparam int ADDR_W = 8;

  // output_control_upper fields
  localparam int OCU_TRIP_EN   = 7;
  localparam int OCU_TRIP_FLAG = 6;
  localparam int OCU_FILT_EN   = 5;
  localparam int OCU_XFER_LO   = 2;
  localparam int OCU_WT_FLAG   = 1;
  localparam int OCU_WT_IE     = 0;
  localparam logic [7:0] OCU_RESET = 8'h00;

  // timer_ctrl_status fields
  localparam int TCS_RUN   = 0;
  localparam int TCS_CLEAR = 1;
  localparam int TCS_MODE  = 2;
  localparam int TCS_PSEL  = 4;
  localparam int PSEL_W    = 2;

  // Read-address bit that selects read-modify-write read behaviour on reads
  localparam int RMW_ADDR_BIT = 7;

  // noise_ctrl_reg filter length field
  localparam int NCR_LEN_LO = 0;

  // Output pin count
  localparam int NUM_OUT = 6;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Machine cycle base for trip filter, 2^n with n = 2 + len_sel
  localparam int FILT_BASE_N = 2;
  localparam int FILT_CNT_W  = 6;

  // Interrupt request levels leaving the block, held while their flags are set and, for trip and write timing, enabled
  typedef struct packed {
    logic compare_clear_irq;
    logic trip_irq;
    logic write_timing_irq;
  } pgt_irq_t;

endpackage

// [pgt_timer_trip.sv]
// Speed timer with compare clear, buffer capture, and trip input control
// Assumes write_timing and position_detect are one-cycle pulses on mclk
// Contract
// - Counter adds one on each cycle its selected prescaler tick is high while running.
// - Reset clears the counter at once.
// - Match, software, write-timing and position clears act on count ticks.
// - Mode bit picks write-timing or position event as clear source.
// - Mode 0 clears on write timing, mode 1 on position detection.
// - timer_run starts counting when set and stops it when cleared.
// - Overflow raises no interrupt.
// - Counter wraps to zero past its 16-bit maximum.
// - Counting starts from 0x0000 after reset.
// - Each restart captures the counter into the timer buffer.
// - Counter equal to compare-clear requests interrupt and clears counter.
// - Loading compare-clear equal to counter gives no match until next equality.
// - Compare-clear interrupt shares the write-timing interrupt output.
// - Upper output control is eight bits, reset zero, fixed field order.
// - trip_ctrl_enable lets trip input force latched inactive levels.
// - Enabled trip with low input drives outputs from port_data_latch.
// - Enabled trip falling edge sets trip_flag and trip interrupt.
// - Writing 0 clears trip_flag, writing 1 leaves it.
// - Read-modify-write reads of trip_flag return 1.
// - trip_filter_enable routes trip input through the noise filter.
// - Filter accepts level held 2^n cycles, n from 2 to 5.
// - With filter on, trip input ignored while internal clock is stopped.
`timescale 1ns/1ps
module pgt_timer_trip
  import pgt_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              arst_n,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Prescaler ticks, timer clear events and clock stop
  input  wire logic [3:0]        presc_tick,
  input  wire logic              write_timing,
  input  wire logic              position_detect,
  input  wire logic              clock_stopped,
  // Pins and waveform
  input  wire logic              trip_input,
  input  wire logic [NUM_OUT-1:0] wave_in,
  output logic [NUM_OUT-1:0]     pulse_output,
  // Interrupt requests
  output pgt_irq_t               irq
);

  // Elaboration check: the counter logic serves 16 bits only
  if (CNT_W != 16) begin : g_cnt_w_check
    $error("pgt_timer_trip: counter must be 16 bits");
  end

  logic [7:0]         out_ctrl;
  logic               tmr_run;
  logic               tmr_mode;
  logic [PSEL_W-1:0]  psel;
  logic               soft_clr_pend;
  logic [CNT_W-1:0]   counter;
  logic [CNT_W-1:0]   cmp_clear;
  logic [CNT_W-1:0]   tmr_buffer;
  logic [1:0]         len_sel;
  logic [NUM_OUT-1:0] port_data_latch;
  logic               evt_pend;
  logic               cmp_armed;
  logic               cmp_flag;
  logic               run_q;
  logic [2:0]         trip_sync;
  logic               trip_raw;
  logic               trip_filt;
  logic               trip_level;
  logic               trip_level_q;
  logic [FILT_CNT_W-1:0] filt_cnt;
  logic [FILT_CNT_W-1:0] filt_lim;

  // Write channel bookkeeping
  logic [ADDR_W-1:0]  aw_addr;
  logic               aw_held;
  logic [31:0]        w_data;
  logic               w_held;
  logic               wr_go;
  logic               rd_go;
  logic               tick;
  logic               evt_now;
  logic               cmp_hit;
  logic [CNT_W-1:0]   next_counter;

  assign tick    = tmr_run && presc_tick[psel];
  assign evt_now = tmr_mode ? position_detect : write_timing;
  assign cmp_hit = cmp_armed && (counter == cmp_clear);
  assign wr_go   = aw_held && w_held && !s_axi_bvalid;

  // Address and data acceptance in either order
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held       <= 1'b0;
      aw_addr       <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      w_held       <= 1'b0;
      w_data       <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      unique case (aw_addr)
        OFS_OUT_CTRL_UPPER, OFS_TIMER_CTRL, OFS_COMPARE_CLEAR,
        OFS_NOISE_CTRL, OFS_PORT_LATCH: s_axi_bresp <= RESP_OKAY;
        OFS_TIMER_BUFFER, OFS_COUNTER, OFS_EVENT_STATUS: s_axi_bresp <= RESP_OKAY;
        default: s_axi_bresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register writes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tmr_run         <= 1'b0;
      tmr_mode        <= 1'b0;
      psel            <= '0;
      cmp_clear       <= '0;
      len_sel         <= '0;
      port_data_latch <= '0;
    end else if (wr_go && s_axi_wstrb[0]) begin
      unique case (aw_addr)
        OFS_TIMER_CTRL: begin
          tmr_run  <= w_data[TCS_RUN];
          tmr_mode <= w_data[TCS_MODE];
          psel     <= w_data[TCS_PSEL +: PSEL_W];
        end
        OFS_NOISE_CTRL: len_sel <= w_data[NCR_LEN_LO +: 2];
        OFS_PORT_LATCH: port_data_latch <= w_data[NUM_OUT-1:0];
        OFS_COMPARE_CLEAR: begin
          cmp_clear[7:0] <= w_data[7:0];
          if (s_axi_wstrb[1]) cmp_clear[15:8] <= w_data[15:8];
        end
        default: ;
      endcase
    end else if (wr_go && s_axi_wstrb[1] && aw_addr == OFS_COMPARE_CLEAR) begin
      cmp_clear[15:8] <= w_data[15:8];
    end
  end

  // output_control_upper with hardware-set flags
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      out_ctrl <= OCU_RESET;
    end else begin
      if (wr_go && s_axi_wstrb[0] && aw_addr == OFS_OUT_CTRL_UPPER) begin
        out_ctrl[OCU_TRIP_EN]            <= w_data[OCU_TRIP_EN];
        out_ctrl[OCU_FILT_EN]            <= w_data[OCU_FILT_EN];
        out_ctrl[OCU_XFER_LO +: 3]       <= w_data[OCU_XFER_LO +: 3];
        out_ctrl[OCU_WT_IE]              <= w_data[OCU_WT_IE];
        if (!w_data[OCU_TRIP_FLAG]) out_ctrl[OCU_TRIP_FLAG] <= 1'b0;
        if (!w_data[OCU_WT_FLAG]) out_ctrl[OCU_WT_FLAG] <= 1'b0;
      end
      if (out_ctrl[OCU_TRIP_EN] && trip_level_q && !trip_level) begin
        out_ctrl[OCU_TRIP_FLAG] <= 1'b1;
      end
      if (write_timing) out_ctrl[OCU_WT_FLAG] <= 1'b1;
    end
  end

  // Software clear request, applied at the next count tick
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      soft_clr_pend <= 1'b0;
    end else if (wr_go && s_axi_wstrb[0] && aw_addr == OFS_TIMER_CTRL
                 && w_data[TCS_CLEAR] && tmr_run) begin
      soft_clr_pend <= 1'b1;
    end else if (tick) begin
      soft_clr_pend <= 1'b0;
    end
  end

  // Event clear request, held until the next count tick
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      evt_pend <= 1'b0;
    end else if (evt_now) begin
      evt_pend <= 1'b1;
    end else if (tick) begin
      evt_pend <= 1'b0;
    end
  end

  // Counter: reset is immediate, other clears wait for the count tick
  always_comb begin
    next_counter = counter;
    if (tick) begin
      if (soft_clr_pend || evt_pend || evt_now || cmp_hit) begin
        next_counter = '0;
      end else begin
        next_counter = counter + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      counter <= 16'h0000;
    end else begin
      counter <= next_counter;
    end
  end

  // Compare arming: a load equal to the counter waits for a later equality
  // Reset and clears land on zero, so zero must be left before it can match
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmp_armed <= 1'b0;
    end else if (wr_go && aw_addr == OFS_COMPARE_CLEAR && |s_axi_wstrb[1:0]) begin
      cmp_armed <= 1'b0;
    end else if (tick && next_counter == '0) begin
      cmp_armed <= 1'b0;
    end else if (counter != cmp_clear) begin
      cmp_armed <= 1'b1;
    end
  end

  // Compare hit flag, cleared by writing 0 to its status bit
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmp_flag <= 1'b0;
    end else if (tick && cmp_hit) begin
      cmp_flag <= 1'b1;
    end else if (wr_go && s_axi_wstrb[0] && aw_addr == OFS_EVENT_STATUS && !w_data[0]) begin
      cmp_flag <= 1'b0;
    end
  end

  // Buffer capture on restart
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      run_q      <= 1'b0;
      tmr_buffer <= '0;
    end else begin
      run_q <= tmr_run;
      if (tmr_run && !run_q) tmr_buffer <= counter;
    end
  end

  // Trip pin synchroniser, accepted once second and third stages agree
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      trip_sync <= 3'b111;
      trip_raw  <= 1'b1;
    end else begin
      trip_sync <= {trip_sync[1:0], trip_input};
      if (trip_sync[1] == trip_sync[2]) trip_raw <= trip_sync[2];
    end
  end

  // Noise filter: low level must persist 2^n cycles
  assign filt_lim = FILT_CNT_W'(1) << (FILT_BASE_N + len_sel);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      filt_cnt  <= '0;
      trip_filt <= 1'b1;
    end else if (clock_stopped) begin
      filt_cnt  <= '0;
    end else if (trip_raw == trip_filt) begin
      filt_cnt  <= '0;
    end else if (filt_cnt == filt_lim - FILT_CNT_W'(1)) begin
      filt_cnt  <= '0;
      trip_filt <= trip_raw;
    end else begin
      filt_cnt  <= filt_cnt + FILT_CNT_W'(1);
    end
  end

  assign trip_level = out_ctrl[OCU_FILT_EN] ? trip_filt : trip_raw;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      trip_level_q <= 1'b1;
    end else begin
      trip_level_q <= trip_level;
    end
  end

  // Output pins and interrupts
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_output <= '0;
      irq          <= '0;
    end else begin
      if (out_ctrl[OCU_TRIP_EN] && !trip_level) begin
        pulse_output <= port_data_latch;
      end else begin
        pulse_output <= wave_in;
      end
      irq.trip_irq          <= out_ctrl[OCU_TRIP_FLAG] && out_ctrl[OCU_TRIP_EN];
      irq.compare_clear_irq <= cmp_flag;
      irq.write_timing_irq  <= (out_ctrl[OCU_WT_FLAG] && out_ctrl[OCU_WT_IE])
                               || cmp_flag;
    end
  end

  // Read channel; address bit RMW_ADDR_BIT marks a read-modify-write read
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        s_axi_rdata  <= '0;
        unique case ({1'b0, s_axi_araddr[RMW_ADDR_BIT-1:0]})
          OFS_OUT_CTRL_UPPER: begin
            s_axi_rdata[7:0] <= out_ctrl;
            if (s_axi_araddr[RMW_ADDR_BIT]) begin
              s_axi_rdata[OCU_TRIP_FLAG] <= 1'b1;
              s_axi_rdata[OCU_WT_FLAG]   <= 1'b1;
            end
          end
          OFS_TIMER_CTRL: s_axi_rdata[7:0] <= {2'b00, psel, 1'b0, tmr_mode, 1'b0, tmr_run};
          OFS_COMPARE_CLEAR: s_axi_rdata[15:0] <= cmp_clear;
          OFS_TIMER_BUFFER:  s_axi_rdata[15:0] <= tmr_buffer;
          OFS_COUNTER:       s_axi_rdata[15:0] <= counter;
          OFS_NOISE_CTRL:    s_axi_rdata[1:0]  <= len_sel;
          OFS_PORT_LATCH:    s_axi_rdata[NUM_OUT-1:0] <= port_data_latch;
          OFS_EVENT_STATUS:  s_axi_rdata[1:0]  <= {trip_level, cmp_flag};
          default:           s_axi_rresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// [pgt_partner.sv]
// Far-side model: prescaler, write timing, position sensor and trip pin
// Driven through its tasks by tb; changes land just after a rising edge
`timescale 1ns/1ps
module pgt_partner (
  // Clock
  input  wire logic mclk,
  // Signals into the block
  output logic [3:0] presc_tick,
  output logic       write_timing,
  output logic       position_detect,
  output logic       trip_input
);
  initial begin
    presc_tick = 4'h0;
    write_timing = 1'b0;
    position_detect = 1'b0;
    trip_input = 1'b1;
  end
  task automatic tick(input int idx, input int n);
    repeat (n) begin
      @(posedge mclk);
      presc_tick[idx] <= 1'b1;
      @(posedge mclk);
      presc_tick[idx] <= 1'b0;
    end
  endtask
  task automatic pulse(input logic wt, input logic pd);
    @(posedge mclk);
    write_timing <= wt;
    position_detect <= pd;
    @(posedge mclk);
    write_timing <= 1'b0;
    position_detect <= 1'b0;
  endtask
  // Trip pin idles high and is pulled low for n cycles
  task automatic trip(input int n);
    @(posedge mclk);
    trip_input <= 1'b0;
    repeat (n) @(posedge mclk);
    trip_input <= 1'b1;
  endtask
endmodule

// [pgt_timer_trip_sva.sv]
// Checker for the ports of pgt_timer_trip
// Bound into every pgt_timer_trip instance
`timescale 1ns/1ps
module pgt_chk
  import pgt_pkg::*;
(
  // Clock and reset
  input wire logic         mclk,
  input wire logic         arst_n,
  // Register bus
  input wire logic         s_axi_awvalid,
  input wire logic         s_axi_awready,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_bready,
  input wire logic         s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic         s_axi_rvalid,
  input wire logic         s_axi_rready,
  input wire logic [31:0]  s_axi_rdata,
  input wire logic [1:0]   s_axi_rresp,
  // Pins
  input wire logic         trip_input,
  input wire logic [5:0]   wave_in,
  input wire logic [5:0]   pulse_output,
  input wire pgt_irq_t     irq
);
  logic [5:0] low_age;
  logic [5:0] high_age;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      low_age <= 6'h3F;
    end else if (!trip_input) begin
      low_age <= 6'h00;
    end else if (low_age != 6'h3F) begin
      low_age <= low_age + 6'h01;
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      high_age <= 6'h00;
    end else if (!trip_input) begin
      high_age <= 6'h00;
    end else if (high_age != 6'h3F) begin
      high_age <= high_age + 6'h01;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped before bready");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer changed early");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_aw_cause: assert property (s_axi_awready |-> s_axi_awvalid)
    else $error("awready without awvalid");
  chk_r_resp: assert property (s_axi_rvalid |->
    (s_axi_rresp == RESP_OKAY || s_axi_rresp == RESP_SLVERR)) else $error("bad rresp");
  chk_trip_cause: assert property ($rose(irq.trip_irq) |-> low_age < 6'h30)
    else $error("trip irq without low trip pin");
  chk_out_pass: assert property (high_age == 6'h3F |->
    pulse_output == $past(wave_in)) else $error("output forced with trip high");
  chk_cc_shared: assert property (irq.compare_clear_irq |-> irq.write_timing_irq)
    else $error("compare irq missing on shared line");
  cov_trip: cover property ($rose(irq.trip_irq));
  cov_cmp: cover property ($rose(irq.compare_clear_irq));
  cov_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind pgt_timer_trip pgt_chk pgt_chk_i (
  .mclk(mclk), .arst_n(arst_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .trip_input(trip_input), .wave_in(wave_in),
  .pulse_output(pulse_output), .irq(irq));

// [tb.sv]
// Testbench for pgt_timer_trip over AXI4-Lite
// Far side is pgt_partner; bready and rready stay high throughout
`timescale 1ns/1ps
module tb import pgt_pkg::*;;
  logic mclk, arst_n, awvalid, wvalid, arvalid, clock_stopped;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, presc_tick;
  logic [1:0] bresp, rresp;
  logic write_timing, position_detect, trip_input;
  logic [5:0] wave_in, pulse_output;
  pgt_irq_t irq;
  logic [1:0] wr_resp;
  int num_errors, samples_checked, cyc;
  pgt_timer_trip pgt_timer_trip_i (.mclk(mclk), .arst_n(arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .presc_tick(presc_tick), .write_timing(write_timing), .position_detect(position_detect),
    .clock_stopped(clock_stopped), .trip_input(trip_input), .wave_in(wave_in),
    .pulse_output(pulse_output), .irq(irq));
  pgt_partner pgt_partner_i (.mclk(mclk), .presc_tick(presc_tick),
    .write_timing(write_timing), .position_detect(position_detect), .trip_input(trip_input));
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic done;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1'b1;
        wr_resp = bresp;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1'b1;
        d = rdata;
        r = rresp;
      end
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    cmp(n, e, d);
    cmp({n, "_resp"}, {30'h0, RESP_OKAY}, {30'h0, r});
  endtask
  task automatic irq_is(input string n, input logic e);
    cmp(n, {31'h0, e}, {31'h0, irq.trip_irq});
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    arst_n = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    clock_stopped = 1'b0;
    wave_in = 6'h15;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    rc(OFS_OUT_CTRL_UPPER, 32'h0, "ocu_reset");
    rc(OFS_COUNTER, 32'h0, "cnt_reset");
    rd(8'h24, d, r);
    cmp("unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(8'h24, 32'h0, 4'h1);
    cmp("unmapped_wr", {30'h0, RESP_SLVERR}, {30'h0, wr_resp});
    $display("test reset done");
    wr(OFS_TIMER_CTRL, 32'h11, 4'h1);
    cmp("wr_resp", {30'h0, RESP_OKAY}, {30'h0, wr_resp});
    pgt_partner_i.tick(1, 5);
    pgt_partner_i.tick(0, 3);
    rc(OFS_COUNTER, 32'h5, "cnt_count");
    wr(OFS_TIMER_CTRL, 32'h10, 4'h1);
    pgt_partner_i.tick(1, 2);
    rc(OFS_COUNTER, 32'h5, "cnt_stopped");
    wr(OFS_TIMER_CTRL, 32'h11, 4'h1);
    rc(OFS_TIMER_BUFFER, 32'h5, "buf_capture");
    wr(OFS_TIMER_CTRL, 32'h13, 4'h1);
    rc(OFS_COUNTER, 32'h5, "clr_waits");
    pgt_partner_i.tick(1, 1);
    rc(OFS_COUNTER, 32'h0, "clr_tick");
    $display("test counting done");
    for (int m = 0; m < 2; m++) begin
      wr(OFS_TIMER_CTRL, 32'h11 | (32'(m) << 2), 4'h1);
      pgt_partner_i.tick(1, 3);
      pgt_partner_i.pulse(m == 1, m == 0);
      pgt_partner_i.tick(1, 1);
      rc(OFS_COUNTER, 32'h4, "other_src");
      pgt_partner_i.pulse(m == 0, m == 1);
      pgt_partner_i.tick(1, 1);
      rc(OFS_COUNTER, 32'h0, "own_src");
    end
    wr(OFS_COMPARE_CLEAR, 32'h3, 4'h3);
    pgt_partner_i.tick(1, 4);
    rc(OFS_COUNTER, 32'h0, "cmp_clear");
    cmp("cmp_irq", 32'h3, {30'h0, irq.compare_clear_irq, irq.write_timing_irq});
    wr(OFS_EVENT_STATUS, 32'h0, 4'h1);
    rc(OFS_EVENT_STATUS, 32'h2, "cmp_flag_clr");
    pgt_partner_i.tick(1, 2);
    wr(OFS_COMPARE_CLEAR, 32'h2, 4'h3);
    pgt_partner_i.tick(1, 1);
    rc(OFS_COUNTER, 32'h3, "cmp_load_eq");
    $display("test timer clears done");
    wr(OFS_PORT_LATCH, 32'h2A, 4'h1);
    wr(OFS_OUT_CTRL_UPPER, 32'h80, 4'h1);
    pgt_partner_i.trip(12);
    cmp("out_forced", 32'h2A, {26'h0, pulse_output});
    irq_is("trip_irq", 1'b1);
    wr(OFS_OUT_CTRL_UPPER, 32'hC0, 4'h1);
    rc(OFS_OUT_CTRL_UPPER, 32'hC0, "flag_kept");
    wr(OFS_OUT_CTRL_UPPER, 32'h80, 4'h1);
    rc(OFS_OUT_CTRL_UPPER, 32'h80, "flag_clr");
    rc(OFS_OUT_CTRL_UPPER | 8'h80, 32'hC2, "rmw_read");
    cmp("out_free", 32'h15, {26'h0, pulse_output});
    wr(OFS_OUT_CTRL_UPPER, 32'hA0, 4'h1);
    for (int n = 0; n < 4; n++) begin
      wr(OFS_NOISE_CTRL, 32'(n), 4'h1);
      pgt_partner_i.trip(2 << n);
      repeat (8) @(posedge mclk);
      irq_is("filt_short", 1'b0);
      pgt_partner_i.trip((4 << n) + 8);
      repeat (4) @(posedge mclk);
      irq_is("filt_long", 1'b1);
      wr(OFS_OUT_CTRL_UPPER, 32'hA0, 4'h1);
      repeat (40) @(posedge mclk);
    end
    wr(OFS_NOISE_CTRL, 32'h0, 4'h1);
    clock_stopped <= 1'b1;
    pgt_partner_i.trip(12);
    repeat (8) @(posedge mclk);
    irq_is("stopped", 1'b0);
    clock_stopped <= 1'b0;
    wr(OFS_OUT_CTRL_UPPER, 32'h80, 4'h1);
    pgt_partner_i.trip(2);
    repeat (8) @(posedge mclk);
    irq_is("bypass", 1'b1);
    $display("test trip done");
    conclude();
  end
endmodule
